// ==== hw/sbc_mode_ctrl.v ====
// Purpose: Operating-mode sequencer and pin control of a system basis chip
// Assumes: Analog comparators arrive asynchronous; 8-bit SPI mode 0, MSB first
// Notes: Long timers are parameters so a simulation can shorten them
`timescale 1ns/1ps
`include "sbc_defines.vh"

module sbc_mode_ctrl #(
   parameter NREQ_CYC = `SBC_NREQ_CYC,
   parameter WD_CYC = `SBC_WD_CYC,
   parameter RST_DUR_CYC = `SBC_RST_DUR_CYC,
   parameter HS_PERIOD_CYC = 2000000,
   parameter HS_ON_CYC = 20000,
   parameter FWU_CYC = 10000000
) (
   input wire sys_clk,
   input wire rst_b,
   input wire can_tx_in,
   output reg can_rx_out,
   input wire can_bus_dominant,
   output reg can_bus_drive_dominant,
   input wire thermal_warn,
   input wire thermal_shutdown,
   input wire main_uv,
   input wire supply_low,
   input wire secondary_fail,
   input wire hs_overtemp,
   input wire wake_input_0,
   input wire wake_input_1,
   input wire spi_sclk,
   input wire spi_cs_n,
   input wire spi_mosi,
   output reg spi_miso,
   output reg reset_out_n,
   output reg irq_out_n,
   output reg wd_fault_out_n,
   output reg main_regulator_on,
   output reg main_regulator_lowpower,
   output reg secondary_reg_drive,
   output reg high_side_switch,
   output reg can_enable,
   output reg [2:0] mode_out
);

   // ****************************************
   // Input synchronisers
   // ****************************************
   localparam NSYNC = 13;
   wire [NSYNC-1:0] async_in;
   reg [NSYNC-1:0] sync1_reg;
   reg [NSYNC-1:0] sync2_reg;
   assign async_in = {can_tx_in, can_bus_dominant, thermal_warn, thermal_shutdown, main_uv,
                      supply_low, secondary_fail, hs_overtemp, wake_input_0, wake_input_1,
                      spi_sclk, spi_cs_n, spi_mosi};
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         sync1_reg <= 13'h1002;
         sync2_reg <= 13'h1002;
      end else begin
         sync1_reg <= async_in;
         sync2_reg <= sync1_reg;
      end
   end
   wire tx_s = sync2_reg[12];
   wire bus_dom_s = sync2_reg[11];
   wire twarn_s = sync2_reg[10];
   wire tsd_s = sync2_reg[9];
   wire uv_s = sync2_reg[8];
   wire slow_s = sync2_reg[7];
   wire v2fail_s = sync2_reg[6];
   wire hsot_s = sync2_reg[5];
   wire w0_s = sync2_reg[4];
   wire w1_s = sync2_reg[3];
   wire sclk_s = sync2_reg[2];
   wire cs_s = sync2_reg[1];
   wire mosi_s = sync2_reg[0];

   // ****************************************
   // Transceiver relay
   // ****************************************
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         can_bus_drive_dominant <= 1'b0;
         can_rx_out <= 1'b1;
      end else begin
         can_bus_drive_dominant <= can_enable & ~tx_s;
         can_rx_out <= ~bus_dom_s;
      end
   end

   // ****************************************
   // SPI slave, eight-bit frames
   // ****************************************
   reg sclk_d_reg;
   reg cs_d_reg;
   reg [2:0] bit_cnt_reg;
   reg [7:0] rx_sh_reg;
   reg [7:0] tx_sh_reg;
   reg frame_ok_reg;
   reg [7:0] frame_reg;
   reg frame_stb_reg;
   wire sclk_rise = sclk_s & ~sclk_d_reg;
   wire sclk_fall = ~sclk_s & sclk_d_reg;
   wire cs_fall = ~cs_s & cs_d_reg;
   wire cs_rise = cs_s & ~cs_d_reg;
   wire [7:0] status_word;
   reg [2:0] mode_reg;
   reg therm_flag_reg;
   reg supply_fail_flag;
   wire [3:0] io_status_reg = {hsot_s, v2fail_s, therm_flag_reg, slow_s};
   assign status_word = {supply_fail_flag, w1_s, w0_s, io_status_reg[3:1], mode_reg[1:0]};
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         sclk_d_reg <= 1'b0;
         cs_d_reg <= 1'b1;
         bit_cnt_reg <= 3'h0;
         rx_sh_reg <= 8'h00;
         tx_sh_reg <= 8'h00;
         frame_ok_reg <= 1'b0;
         frame_reg <= 8'h00;
         frame_stb_reg <= 1'b0;
         spi_miso <= 1'b0;
      end else begin
         sclk_d_reg <= sclk_s;
         cs_d_reg <= cs_s;
         frame_stb_reg <= 1'b0;
         if (cs_fall) begin
            bit_cnt_reg <= 3'h0;
            frame_ok_reg <= 1'b0;
            tx_sh_reg <= {status_word[6:0], 1'b0};
            spi_miso <= status_word[7];
         end else if (!cs_s && sclk_rise) begin
            rx_sh_reg <= {rx_sh_reg[6:0], mosi_s};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            frame_ok_reg <= (bit_cnt_reg == 3'h7);
         end else if (!cs_s && sclk_fall) begin
            spi_miso <= tx_sh_reg[7];
            tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
         end else if (cs_rise && frame_ok_reg) begin
            frame_reg <= rx_sh_reg;
            frame_stb_reg <= 1'b1;
         end
      end
   end
   wire [2:0] cmd = frame_reg[`SBC_FLD_CMD_LSB+2:`SBC_FLD_CMD_LSB];

   // ****************************************
   // Control registers and flags
   // ****************************************
   reg [1:0] irq_enable_reg;
   reg wd_in_stop_enable;
   reg hs_cmd_reg;
   reg wd_cfg_seen_reg;
   reg twarn_d_reg;
   reg slow_d_reg;
   wire read_mode_reg = frame_stb_reg && (frame_reg == 8'h00);
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         irq_enable_reg <= 2'h3;
         wd_in_stop_enable <= 1'b0;
         hs_cmd_reg <= 1'b0;
         therm_flag_reg <= 1'b0;
         supply_fail_flag <= 1'b0;
         twarn_d_reg <= 1'b0;
         slow_d_reg <= 1'b0;
      end else begin
         twarn_d_reg <= twarn_s;
         slow_d_reg <= slow_s;
         if (twarn_s && !twarn_d_reg) begin
            therm_flag_reg <= 1'b1;
         end else if (frame_stb_reg && frame_reg == 8'h01) begin
            therm_flag_reg <= 1'b0;
         end
         if (slow_s && !slow_d_reg) begin
            supply_fail_flag <= 1'b1;
         end else if (read_mode_reg) begin
            supply_fail_flag <= 1'b0;
         end
         if (frame_stb_reg && frame_reg[7:5] == 3'h1) begin
            irq_enable_reg <= frame_reg[1:0];
            hs_cmd_reg <= frame_reg[2];
         end
         if (frame_stb_reg && cmd == `SBC_CMD_STOP) begin
            wd_in_stop_enable <= frame_reg[`SBC_FLD_WD_IN_STOP_ENABLE];
         end
      end
   end

   // ****************************************
   // Mode state machine
   // ****************************************
   reg [31:0] tmr_reg;
   reg [31:0] wd_reg;
   reg [31:0] hs_tmr_reg;
   reg [15:0] pulse_reg;
   reg w0_ref_reg;
   reg w1_ref_reg;
   reg stop_pend_reg;
   reg [15:0] stop_dly_reg;
   reg wd_clr_early_reg;
   wire low_power = (mode_reg == `SBC_MODE_SLEEP) || (mode_reg == `SBC_MODE_STOP);
   wire wake_in = (w0_s != w0_ref_reg) || (w1_s != w1_ref_reg);
   wire fwu_hit = (hs_tmr_reg >= FWU_CYC[31:0]);
   wire wake_evt = low_power & (wake_in | bus_dom_s | cs_rise | fwu_hit);
   wire wd_runs = (mode_reg == `SBC_MODE_NORMAL) || (mode_reg == `SBC_MODE_STANDBY) ||
                  ((mode_reg == `SBC_MODE_STOP) && wd_in_stop_enable);
   wire wd_expire = wd_runs && (wd_reg >= WD_CYC[31:0]);
   wire wd_clr = frame_stb_reg && (cmd == `SBC_CMD_WDCLR);
   wire wd_bad = wd_clr && wd_reg < (WD_CYC[31:0] >> 1) && (mode_reg != `SBC_MODE_STOP);
   wire [31:0] wake_pulse_cyc = `SBC_WAKE_PULSE_CYC;
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         mode_reg <= `SBC_MODE_RESET;
         tmr_reg <= 32'h0;
         wd_reg <= 32'h0;
         hs_tmr_reg <= 32'h0;
         pulse_reg <= 16'h0;
         w0_ref_reg <= 1'b0;
         w1_ref_reg <= 1'b0;
         stop_pend_reg <= 1'b0;
         stop_dly_reg <= 16'h0;
         wd_cfg_seen_reg <= 1'b0;
         wd_clr_early_reg <= 1'b0;
      end else begin
         tmr_reg <= tmr_reg + 32'h1;
         wd_reg <= (wd_runs && !wd_clr) ? wd_reg + 32'h1 : 32'h0;
         hs_tmr_reg <= low_power ? hs_tmr_reg + 32'h1 : 32'h0;
         if (pulse_reg != 16'h0) begin
            pulse_reg <= pulse_reg - 16'h1;
         end
         if (!low_power) begin
            w0_ref_reg <= w0_s;
            w1_ref_reg <= w1_s;
         end
         if (wd_bad || wd_expire) begin
            wd_clr_early_reg <= 1'b1;
         end else if (frame_stb_reg && cmd == `SBC_CMD_WDCFG) begin
            wd_clr_early_reg <= 1'b0;
         end
         if (stop_pend_reg) begin
            stop_dly_reg <= stop_dly_reg + 16'h1;
         end
         case (mode_reg)
            `SBC_MODE_RESET: begin
               if (!uv_s && tmr_reg >= RST_DUR_CYC[31:0]) begin
                  mode_reg <= `SBC_MODE_NREQ;
                  tmr_reg <= 32'h0;
               end
            end
            `SBC_MODE_NREQ: begin
               if (frame_stb_reg && cmd == `SBC_CMD_WDCFG) begin
                  mode_reg <= `SBC_MODE_NORMAL;
                  wd_cfg_seen_reg <= 1'b1;
               end else if (tmr_reg >= NREQ_CYC[31:0]) begin
                  mode_reg <= `SBC_MODE_RESET;
                  tmr_reg <= 32'h0;
               end
            end
            `SBC_MODE_NORMAL, `SBC_MODE_STANDBY: begin
               if (wd_bad || wd_expire) begin
                  mode_reg <= `SBC_MODE_RESET;
                  tmr_reg <= 32'h0;
               end else if (stop_pend_reg) begin
                  if (stop_dly_reg >= `SBC_STOP_DLY_CYC - 1) begin
                     mode_reg <= `SBC_MODE_STOP;
                     stop_pend_reg <= 1'b0;
                  end
               end else if (frame_stb_reg) begin
                  case (cmd)
                     `SBC_CMD_NORMAL: mode_reg <= `SBC_MODE_NORMAL;
                     `SBC_CMD_STANDBY: mode_reg <= `SBC_MODE_STANDBY;
                     `SBC_CMD_SLEEP: mode_reg <= `SBC_MODE_SLEEP;
                     `SBC_CMD_STOP: begin
                        stop_pend_reg <= 1'b1;
                        stop_dly_reg <= 16'h0;
                     end
                     default: mode_reg <= mode_reg;
                  endcase
               end
            end
            `SBC_MODE_SLEEP: begin
               if (wake_evt) begin
                  mode_reg <= `SBC_MODE_RESET;
                  tmr_reg <= 32'h0;
               end
            end
            `SBC_MODE_STOP: begin
               if (wd_expire) begin
                  mode_reg <= `SBC_MODE_RESET;
                  tmr_reg <= 32'h0;
               end else if (wake_evt) begin
                  mode_reg <= `SBC_MODE_NREQ;
                  tmr_reg <= 32'h0;
                  pulse_reg <= wake_pulse_cyc[15:0];
               end
            end
            default: mode_reg <= `SBC_MODE_RESET;
         endcase
      end
   end

   // ****************************************
   // Output drive
   // ****************************************
   wire irq_src = (irq_enable_reg[0] & therm_flag_reg) | (irq_enable_reg[1] & supply_fail_flag);
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         reset_out_n <= 1'b0;
         irq_out_n <= 1'b1;
         wd_fault_out_n <= 1'b1;
         main_regulator_on <= 1'b1;
         main_regulator_lowpower <= 1'b0;
         secondary_reg_drive <= 1'b0;
         high_side_switch <= 1'b0;
         can_enable <= 1'b0;
         mode_out <= `SBC_MODE_RESET;
      end else begin
         reset_out_n <= (mode_reg != `SBC_MODE_RESET) && !uv_s;
         irq_out_n <= !(irq_src || pulse_reg != 16'h0);
         wd_fault_out_n <= !wd_clr_early_reg;
         main_regulator_on <= (mode_reg != `SBC_MODE_SLEEP) && !tsd_s;
         main_regulator_lowpower <= (mode_reg == `SBC_MODE_STOP);
         secondary_reg_drive <= (mode_reg == `SBC_MODE_NORMAL);
         can_enable <= (mode_reg == `SBC_MODE_NORMAL);
         if (mode_reg == `SBC_MODE_SLEEP) begin
            high_side_switch <= (hs_tmr_reg % HS_PERIOD_CYC) < HS_ON_CYC;
         end else begin
            high_side_switch <= hs_cmd_reg && (mode_reg == `SBC_MODE_NORMAL ||
                                               mode_reg == `SBC_MODE_STANDBY);
         end
         mode_out <= mode_reg;
      end
   end

endmodule // sbc_mode_ctrl

// ==== inc/sbc_defines.vh ====
// Purpose: Shared constants for the mode and pin control block
// Assumes: 100 MHz system clock
// Notes: Definitions only
`ifndef SBC_DEFINES_VH
`define SBC_DEFINES_VH

// ****************************************
// Operating modes
// ****************************************
`define SBC_MODE_RESET 3'h0
`define SBC_MODE_NREQ 3'h1
`define SBC_MODE_NORMAL 3'h2
`define SBC_MODE_STANDBY 3'h3
`define SBC_MODE_SLEEP 3'h4
`define SBC_MODE_STOP 3'h5

// ****************************************
// Command codes (high three bits of the mode command frame)
// ****************************************
`define SBC_CMD_NORMAL 3'h2
`define SBC_CMD_STANDBY 3'h3
`define SBC_CMD_SLEEP 3'h4
`define SBC_CMD_STOP 3'h5
`define SBC_CMD_WDCFG 3'h6
`define SBC_CMD_WDCLR 3'h7

// ****************************************
// Frame and field layout
// ****************************************
`define SBC_FRAME_BITS 8
`define SBC_FLD_CMD_LSB 5
`define SBC_FLD_WD_IN_STOP_ENABLE 4

// ****************************************
// Timing in microseconds, milliseconds and clock cycles, clock in MHz
// ****************************************
`define SBC_CLK_MHZ 100
`define SBC_STOP_DLY_US 20
`define SBC_WAKE_PULSE_US 10
`define SBC_NREQ_TIME_MS 350
`define SBC_STOP_DLY_CYC (`SBC_STOP_DLY_US * `SBC_CLK_MHZ)
`define SBC_WAKE_PULSE_CYC (`SBC_WAKE_PULSE_US * `SBC_CLK_MHZ)
`define SBC_NREQ_CYC (`SBC_NREQ_TIME_MS * 1000 * `SBC_CLK_MHZ)
`define SBC_WD_CYC 5000000
`define SBC_RST_DUR_CYC 100000

`endif

// ==== sim/sbc_mode_ctrl_checker.sv ====
// Purpose: Port assertions for the mode and pin control block
// Assumes: One 100 MHz domain, synchronous active-low reset
// Notes: Bound to every instance of the block
`timescale 1ns/1ps
`include "sbc_defines.vh"
module sbc_mode_ctrl_checker (
   input wire sys_clk,
   input wire rst_b,
   input wire can_tx_in,
   input wire can_rx_out,
   input wire can_bus_dominant,
   input wire can_bus_drive_dominant,
   input wire can_enable,
   input wire thermal_shutdown,
   input wire main_uv,
   input wire reset_out_n,
   input wire irq_out_n,
   input wire secondary_reg_drive,
   input wire main_regulator_on,
   input wire main_regulator_lowpower,
   input wire [2:0] mode_out
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);
   property p_tx_dom;
      (!can_tx_in && can_enable) [*4] |-> can_bus_drive_dominant;
   endproperty
   a_tx_dom: assert property (p_tx_dom) else $error("bus not dominant");
   property p_rx;
      (can_enable && $stable(can_bus_dominant)) [*4] |-> can_rx_out == !can_bus_dominant;
   endproperty
   a_rx: assert property (p_rx) else $error("receive level wrong");
   property p_sd;
      thermal_shutdown [*4] |-> !main_regulator_on;
   endproperty
   a_sd: assert property (p_sd) else $error("regulator on in shutdown");
   property p_uv;
      main_uv [*4] |-> !reset_out_n;
   endproperty
   a_uv: assert property (p_uv) else $error("reset high in undervoltage");
   property p_rst_mode;
      (mode_out == `SBC_MODE_RESET) [*2] |-> !$past(reset_out_n);
   endproperty
   a_rst_mode: assert property (p_rst_mode) else $error("reset high in reset mode");
   property p_normal;
      (mode_out == `SBC_MODE_NORMAL) [*2] |-> $past(secondary_reg_drive) && $past(can_enable);
   endproperty
   a_normal: assert property (p_normal) else $error("normal mode supplies off");
   property p_standby;
      (mode_out == `SBC_MODE_STANDBY) [*2] |-> !$past(secondary_reg_drive) && !$past(can_enable);
   endproperty
   a_standby: assert property (p_standby) else $error("standby supplies wrong");
   property p_sleep;
      (mode_out == `SBC_MODE_SLEEP) [*2] |-> !$past(main_regulator_on) && !$past(secondary_reg_drive);
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep regulators on");
   property p_stop;
      (mode_out == `SBC_MODE_STOP) [*2] |-> $past(main_regulator_lowpower) && !$past(secondary_reg_drive);
   endproperty
   a_stop: assert property (p_stop) else $error("stop supplies wrong");
   property p_nreq;
      $changed(mode_out) && mode_out == `SBC_MODE_NREQ |->
         $past(mode_out) == `SBC_MODE_RESET || $past(mode_out) == `SBC_MODE_STOP;
   endproperty
   a_nreq: assert property (p_nreq) else $error("normal request from wrong mode");
   c_stop: cover property (mode_out == `SBC_MODE_STOP);
   c_pulse: cover property ($fell(irq_out_n));
   c_normal: cover property ($rose(mode_out == `SBC_MODE_NORMAL));
endmodule // sbc_mode_ctrl_checker
bind sbc_mode_ctrl sbc_mode_ctrl_checker i_chk (.sys_clk, .rst_b, .can_tx_in, .can_rx_out,
   .can_bus_dominant, .can_bus_drive_dominant, .can_enable, .thermal_shutdown, .main_uv,
   .reset_out_n, .irq_out_n, .secondary_reg_drive, .main_regulator_on,
   .main_regulator_lowpower, .mode_out);

// ==== sim/sbc_mcu_model.sv ====
// Purpose: Controller model with SPI master and CAN transmit pin
// Assumes: SPI mode 0, MSB first, 160 ns clock period
// Notes: SPI clock stands still outside frames
`timescale 1ns/1ps
module sbc_mcu_model (
   output reg spi_sclk,
   output reg spi_cs_n,
   output reg spi_mosi,
   input wire spi_miso,
   output reg can_tx_in
);
   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b1;
      can_tx_in = 1'b1;
   end
   // Exactly eight clocks per frame
   task xfer(input [7:0] tx, output [7:0] rx);
      integer i;
      begin
         spi_cs_n = 1'b0;
         for (i = 7; i >= 0; i = i - 1) begin
            spi_mosi = tx[i];
            #80 spi_sclk = 1'b1;
            rx[i] = spi_miso;
            #80 spi_sclk = 1'b0;
         end
         #80 spi_cs_n = 1'b1;
         spi_mosi = ~tx[0];
         #160;
      end
   endtask
   // Chip-select pulse with no clocks
   task cs_wake;
      begin
         spi_cs_n = 1'b0;
         #160 spi_cs_n = 1'b1;
         #160;
      end
   endtask
endmodule // sbc_mcu_model

// ==== sim/sbc_mode_ctrl_tb.sv ====
// Purpose: Self-checking bench for the mode and pin control block
// Assumes: Shortened timers, 100 MHz clock
// Notes: Drives inputs at the falling edge
`timescale 1ns/1ps
`include "sbc_defines.vh"
module sbc_mode_ctrl_tb;
   reg sys_clk = 1'b0;
   reg rst_b = 1'b0;
   reg other_dom = 1'b0;
   reg thermal_warn = 1'b0;
   reg thermal_shutdown = 1'b0;
   reg main_uv = 1'b0;
   reg supply_low = 1'b0;
   reg secondary_fail = 1'b0;
   reg hs_overtemp = 1'b0;
   reg wake_input_0 = 1'b0;
   reg wake_input_1 = 1'b0;
   wire can_tx_in, can_rx_out, can_bus_dominant, can_bus_drive_dominant;
   wire spi_sclk, spi_cs_n, spi_mosi, spi_miso, reset_out_n, irq_out_n, wd_fault_out_n;
   wire main_regulator_on, main_regulator_lowpower, secondary_reg_drive;
   wire high_side_switch, can_enable;
   wire [2:0] mode_out;
   integer fails = 0;
   integer tests_run = 0;
   integer n;
   reg [7:0] rx;
   localparam [15:0] pulse_exp = `SBC_WAKE_PULSE_CYC;
   always #5 sys_clk = ~sys_clk;
   assign can_bus_dominant = can_bus_drive_dominant | other_dom;
   sbc_mcu_model i_mcu (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
      .spi_miso(spi_miso), .can_tx_in(can_tx_in));
   sbc_mode_ctrl #(.NREQ_CYC(2000), .WD_CYC(3000), .RST_DUR_CYC(50), .HS_PERIOD_CYC(2000),
      .HS_ON_CYC(20), .FWU_CYC(5000)) i_dut (.sys_clk(sys_clk), .rst_b(rst_b),
      .can_tx_in(can_tx_in), .can_rx_out(can_rx_out), .can_bus_dominant(can_bus_dominant),
      .can_bus_drive_dominant(can_bus_drive_dominant), .thermal_warn(thermal_warn),
      .thermal_shutdown(thermal_shutdown), .main_uv(main_uv), .supply_low(supply_low),
      .secondary_fail(secondary_fail), .hs_overtemp(hs_overtemp),
      .wake_input_0(wake_input_0), .wake_input_1(wake_input_1), .spi_sclk(spi_sclk),
      .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
      .reset_out_n(reset_out_n), .irq_out_n(irq_out_n), .wd_fault_out_n(wd_fault_out_n),
      .main_regulator_on(main_regulator_on), .main_regulator_lowpower(main_regulator_lowpower),
      .secondary_reg_drive(secondary_reg_drive), .high_side_switch(high_side_switch),
      .can_enable(can_enable), .mode_out(mode_out));
   task chk(input [8*10:1] name, input [15:0] exp, input [15:0] got);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("[ERR] %0s exp %h got %h", name, exp, got);
         end
      end
   endtask
   task wait_mode(input [2:0] m, input integer lim);
      begin
         n = 0;
         while (mode_out !== m && n < lim) begin
            @(negedge sys_clk);
            n = n + 1;
         end
         chk("mode_out", {13'h0, m}, {13'h0, mode_out});
      end
   endtask
   task cmd(input [7:0] b);
      begin
         i_mcu.xfer(b, rx);
         @(negedge sys_clk);
      end
   endtask
   task tally_and_finish;
      begin
         if (fails == 0 && tests_run > 0) begin
            $display("bench passed");
         end else begin
            $display("bench failed");
         end
         $finish;
      end
   endtask
   initial begin
      #500000;
      fails = fails + 1;
      tally_and_finish;
   end
   initial begin
      repeat (8) @(negedge sys_clk);
      chk("rst_out", 16'h0, {15'h0, reset_out_n});
      rst_b = 1'b1;
      wait_mode(`SBC_MODE_NREQ, 200);
      chk("rst_out", 16'h1, {15'h0, reset_out_n});
      cmd(8'hc0);
      wait_mode(`SBC_MODE_NORMAL, 20);
      chk("v2_drive", 16'h1, {15'h0, secondary_reg_drive});
      i_mcu.can_tx_in = 1'b0;
      repeat (7) @(negedge sys_clk);
      chk("bus_drive", 16'h1, {15'h0, can_bus_drive_dominant});
      chk("can_rx", 16'h0, {15'h0, can_rx_out});
      i_mcu.can_tx_in = 1'b1;
      other_dom = 1'b1;
      repeat (5) @(negedge sys_clk);
      chk("bus_drive", 16'h0, {15'h0, can_bus_drive_dominant});
      chk("can_rx", 16'h0, {15'h0, can_rx_out});
      other_dom = 1'b0;
      {supply_low, secondary_fail, hs_overtemp, thermal_warn, wake_input_0} = 5'h1f;
      repeat (5) @(negedge sys_clk);
      chk("can_rx", 16'h1, {15'h0, can_rx_out});
      chk("irq_out", 16'h0, {15'h0, irq_out_n});
      cmd(8'h00);
      chk("status", 16'hbe, {8'h0, rx});
      {supply_low, secondary_fail, hs_overtemp, thermal_warn, wake_input_0} = 5'h00;
      wake_input_1 = 1'b1;
      repeat (5) @(negedge sys_clk);
      cmd(8'h01);
      chk("status", 16'h42, {8'h0, rx & 8'he3});
      chk("irq_out", 16'h1, {15'h0, irq_out_n});
      cmd(8'h60);
      wait_mode(`SBC_MODE_STANDBY, 20);
      cmd(8'h27);
      chk("hs_switch", 16'h1, {15'h0, high_side_switch});
      cmd(8'h40);
      wait_mode(`SBC_MODE_NORMAL, 20);
      cmd(8'he0);
      repeat (10) @(negedge sys_clk);
      chk("wd_fault", 16'h0, {15'h0, wd_fault_out_n});
      wait_mode(`SBC_MODE_NREQ, 3500);
      cmd(8'hc0);
      wait_mode(`SBC_MODE_NORMAL, 20);
      chk("wd_fault", 16'h1, {15'h0, wd_fault_out_n});
      cmd(8'ha0);
      repeat (1960) @(negedge sys_clk);
      chk("mode_out", {13'h0, `SBC_MODE_NORMAL}, {13'h0, mode_out});
      wait_mode(`SBC_MODE_STOP, 80);
      fork
         i_mcu.cs_wake;
         begin
            n = 0;
            while (irq_out_n !== 1'b0 && n < 200) begin
               @(negedge sys_clk);
               n = n + 1;
            end
            n = 0;
            while (irq_out_n === 1'b0 && n < 2000) begin
               @(negedge sys_clk);
               n = n + 1;
            end
         end
      join
      chk("irq_pulse", pulse_exp, n[15:0]);
      wait_mode(`SBC_MODE_NREQ, 100);
      cmd(8'hc0);
      wait_mode(`SBC_MODE_NORMAL, 20);
      cmd(8'h80);
      wait_mode(`SBC_MODE_SLEEP, 20);
      wake_input_1 = 1'b0;
      wait_mode(`SBC_MODE_RESET, 50);
      wait_mode(`SBC_MODE_NREQ, 200);
      cmd(8'hc0);
      wait_mode(`SBC_MODE_NORMAL, 20);
      cmd(8'hb0);
      wait_mode(`SBC_MODE_STOP, 2100);
      wait_mode(`SBC_MODE_RESET, 3200);
      wait_mode(`SBC_MODE_NREQ, 200);
      main_uv = 1'b1;
      thermal_shutdown = 1'b1;
      repeat (6) @(negedge sys_clk);
      chk("rst_out", 16'h0, {15'h0, reset_out_n});
      chk("main_reg", 16'h0, {15'h0, main_regulator_on});
      main_uv = 1'b0;
      thermal_shutdown = 1'b0;
      repeat (6) @(negedge sys_clk);
      chk("rst_out", 16'h1, {15'h0, reset_out_n});
      chk("main_reg", 16'h1, {15'h0, main_regulator_on});
      tally_and_finish;
   end
endmodule // sbc_mode_ctrl_tb
